// ---- verilog/scl_stop_ctrl.sv ----
// Stop-mode clock loss handling and wake-up controller with register port
//
// Summary of operation
// (RULE1) Monitor on, self-clock off: loss resets at once
// (RULE2) Self-clock, interrupt off: stay stopped, start checks
// (RULE3) Good oscillator ends self-clock, PLL, regulator
// (RULE4) Recovered: interrupt or reset exits on oscillator
// (RULE5) Unrecovered: checks repeat forever in pseudo-stop
// (RULE6) Unrecovered exit runs on PLL in self-clock
// (RULE7) Interrupt enabled: loss flag wakes onto PLL
// (RULE8) Only interrupt or external reset leaves full stop
// (RULE9) Full-stop reset: defaults, then up to 50 windows
// (RULE10) Check done starts reset generator, then run
// (RULE11) Full-stop interrupt wake: up to 50 windows
// (RULE12) Successful check releases all clocks
// (RULE13) All windows fail: self-clock or monitor reset
// (RULE14) Stop exit clears PLL select; software resets it
// (RULE15) Clock monitor inactive during full stop
// (RULE16) Pseudo-stop select picks pseudo or full stop
// (RULE17) Window count and length are checker parameters
`timescale 1ns/1ns
module scl_stop_ctrl #(
   parameter int WINDOW_CYCLES = scl_pkg::WINDOW_CYCLES,
   parameter int GOOD_EDGES    = scl_pkg::GOOD_OSC_CYCLES,
   parameter int MAX_WINDOWS   = scl_pkg::MAX_WINDOWS,
   parameter int LOSS_CYCLES   = scl_pkg::LOSS_CYCLES
) (
   input  wire logic                        clock_i,
   input  wire logic                        rst_b_i,
   input  wire logic [scl_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [scl_pkg::DATA_W-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [scl_pkg::DATA_W-1:0]  rdata_o,
   input  wire logic                        stop_req_i,
   input  wire logic                        wake_irq_i,
   input  wire logic                        ext_reset_b_i,
   input  wire logic                        osc_clock_i,
   output scl_pkg::scl_clk_s                clk_ctl_o,
   output logic                             monitor_fail_reset_o,
   output logic                             reset_start_o,
   output logic                             irq_o
);
   import scl_pkg::*;

   localparam int LW = $clog2(LOSS_CYCLES + 1);

   // Pin synchronisers and clock monitor
   logic [SYNC_STAGES-1:0] osc_sync_ff, nxt_osc_sync, rst_sync_ff, nxt_rst_sync;
   logic                   osc_flt_ff, nxt_osc_flt, rst_flt_ff, nxt_rst_flt;
   logic [LW-1:0]          loss_cnt_ff, nxt_loss_cnt;
   logic                   loss_ff, nxt_loss, loss_evt_ff, nxt_loss_evt;
   logic                   osc_rise, ext_fall;

   assign osc_rise = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_flt_ff;
   assign ext_fall = (rst_sync_ff[1] == rst_sync_ff[2]) && !rst_sync_ff[2] && rst_flt_ff;

   always_comb begin
      nxt_osc_sync = {osc_sync_ff[1:0], osc_clock_i};
      nxt_rst_sync = {rst_sync_ff[1:0], ext_reset_b_i};
      nxt_osc_flt  = (osc_sync_ff[1] == osc_sync_ff[2]) ? osc_sync_ff[2] : osc_flt_ff;
      nxt_rst_flt  = (rst_sync_ff[1] == rst_sync_ff[2]) ? rst_sync_ff[2] : rst_flt_ff;
      nxt_loss_cnt = loss_cnt_ff;
      nxt_loss     = loss_ff;
      if (osc_rise) begin
         nxt_loss_cnt = '0;
         nxt_loss     = 1'b0;
      end else if (loss_cnt_ff != LW'(LOSS_CYCLES - 1)) begin
         nxt_loss_cnt = loss_cnt_ff + LW'(1);
      end else begin
         nxt_loss = 1'b1;
      end
      nxt_loss_evt = nxt_loss && !loss_ff;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         osc_sync_ff <= '0;
         rst_sync_ff <= '1;
         osc_flt_ff  <= 1'b0;
         rst_flt_ff  <= 1'b1;
         loss_cnt_ff <= '0;
         loss_ff     <= 1'b0;
         loss_evt_ff <= 1'b0;
      end else begin
         osc_sync_ff <= nxt_osc_sync;
         rst_sync_ff <= nxt_rst_sync;
         osc_flt_ff  <= nxt_osc_flt;
         rst_flt_ff  <= nxt_rst_flt;
         loss_cnt_ff <= nxt_loss_cnt;
         loss_ff     <= nxt_loss;
         loss_evt_ff <= nxt_loss_evt;
      end
   end

   // Quality checker
   logic chk_start, chk_lim, chk_abort, chk_good, chk_tmo, chk_busy;

   scl_quality_check #(
      .WINDOW_CYCLES (WINDOW_CYCLES),
      .GOOD_EDGES    (GOOD_EDGES),
      .MAX_WINDOWS   (MAX_WINDOWS)
   ) u_check (
      .clock_i    (clock_i),
      .rst_b_i    (rst_b_i),
      .start_i    (chk_start),
      .limited_i  (chk_lim),
      .abort_i    (chk_abort),
      .osc_edge_i (osc_rise),
      .good_o     (chk_good),
      .timeout_o  (chk_tmo),
      .busy_o     (chk_busy)
   );

   // Control state and registers
   scl_state_e        state_ff, nxt_state;
   scl_cfg_s          cfg_ff, nxt_cfg;
   scl_clk_s          clk_ff, nxt_clk;
   logic [FLAG_W-1:0] flag_ff, nxt_flag, ien_ff, nxt_ien, flag_set;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic              slf_ff, nxt_slf, wake_rst_ff, nxt_wake_rst;
   logic              mfr_ff, nxt_mfr, rstart_ff, nxt_rstart, irq_ff, nxt_irq;
   logic              mon_active, mon_loss;

   assign mon_active = cfg_ff.clock_monitor_enable
                       && state_ff != ST_FSTOP && state_ff != ST_FCHECK; // RULE15
   assign mon_loss   = mon_active && loss_evt_ff;

   always_comb begin
      nxt_state    = state_ff;
      nxt_cfg      = cfg_ff;
      nxt_flag     = flag_ff;
      nxt_ien      = ien_ff;
      nxt_slf      = slf_ff;
      nxt_wake_rst = wake_rst_ff;
      nxt_mfr      = 1'b0;
      nxt_rstart   = 1'b0;
      nxt_rdata    = '0;
      flag_set     = '0;
      chk_start    = 1'b0;
      chk_lim      = 1'b0;
      chk_abort    = 1'b0;
      if (wr_i) begin
         unique case (addr_i)
            OFS_CTRL:   nxt_cfg  = wdata_i[CTRL_W-1:0];
            OFS_CLEAR:  nxt_flag = flag_ff & ~wdata_i[FLAG_W-1:0];
            OFS_ENABLE: nxt_ien  = wdata_i[FLAG_W-1:0];
            default:    ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            OFS_CTRL:   nxt_rdata = {{(DATA_W-CTRL_W){1'b0}}, cfg_ff};
            OFS_STATUS: nxt_rdata = {{(DATA_W-FLAG_W){1'b0}}, flag_ff};
            OFS_ENABLE: nxt_rdata = {{(DATA_W-FLAG_W){1'b0}}, ien_ff};
            OFS_STATE:  nxt_rdata = {2'h0, chk_busy, slf_ff, state_ff};
            default:    nxt_rdata = '0;
         endcase
      end
      // Oscillator back while running on self-clock
      if (chk_good && slf_ff && state_ff != ST_FCHECK) begin
         nxt_slf = 1'b0; // RULE3
      end
      // Loss while running or in pseudo-stop
      if ((state_ff == ST_RUN || state_ff == ST_PSTOP) && mon_loss && !ext_fall) begin
         if (!cfg_ff.self_clock_mode_enable) begin
            nxt_mfr   = 1'b1; // RULE1
            nxt_cfg   = CFG_RST;
            nxt_state = ST_RUN;
         end else begin
            nxt_slf            = 1'b1; // RULE2
            chk_start          = 1'b1;
            flag_set[FLG_SLF]  = 1'b1;
            if (ien_ff[FLG_SLF]) begin
               nxt_state = ST_RUN; // RULE7
            end
         end
      end
      unique case (state_ff)
         ST_RUN: begin
            if (stop_req_i && !mon_loss) begin
               if (cfg_ff.pseudo_stop_select) begin // RULE16
                  nxt_state = ST_PSTOP;
               end else begin
                  // Full stop halts any check; a fresh one runs on exit
                  nxt_state = ST_FSTOP;
                  chk_abort = 1'b1;
               end
            end
         end
         ST_PSTOP: begin
            if (ext_fall) begin
               nxt_cfg    = CFG_RST; // RULE4
               nxt_rstart = 1'b1;
               nxt_state  = ST_RUN;
            end else if (wake_irq_i && !mon_loss) begin
               nxt_state = ST_RUN; // RULE6
            end
         end
         ST_FSTOP: begin
            if (ext_fall) begin
               nxt_cfg      = CFG_RST; // RULE9
               nxt_wake_rst = 1'b1;
               chk_start    = 1'b1;
               chk_lim      = 1'b1;
               nxt_state    = ST_FCHECK;
            end else if (wake_irq_i) begin
               nxt_wake_rst = 1'b0; // RULE11
               chk_start    = 1'b1;
               chk_lim      = 1'b1;
               nxt_state    = ST_FCHECK; // RULE8
            end
         end
         ST_FCHECK: begin
            if (chk_good) begin
               nxt_slf    = 1'b0; // RULE12
               nxt_rstart = wake_rst_ff; // RULE10
               nxt_state  = ST_RUN;
            end else if (chk_tmo) begin
               nxt_state = ST_RUN;
               if (wake_rst_ff || cfg_ff.self_clock_mode_enable) begin
                  nxt_slf    = 1'b1; // RULE13
                  nxt_rstart = wake_rst_ff;
                  chk_start  = 1'b1;
                  flag_set[FLG_SLF] = !wake_rst_ff;
               end else begin
                  nxt_mfr = 1'b1; // RULE13
                  nxt_cfg = CFG_RST;
               end
            end
         end
      endcase
      // Any stop exit clears PLL select, so the exit lands on the oscillator unless self-clock keeps it on the PLL
      if (state_ff != ST_RUN && nxt_state == ST_RUN) begin
         nxt_cfg.pll_select = 1'b0; // RULE14
      end
      flag_set[FLG_MFAIL] = nxt_mfr;
      flag_set[FLG_GOOD]  = chk_good;
      flag_set[FLG_TMO]   = chk_tmo;
      // Hardware set wins over a clear in the same cycle
      nxt_flag = nxt_flag | flag_set;
      nxt_irq  = |(nxt_flag & nxt_ien);
      nxt_clk.clocks_released  = nxt_state == ST_RUN;
      nxt_clk.in_stop          = nxt_state != ST_RUN;
      nxt_clk.sys_clk_pll      = nxt_slf || nxt_cfg.pll_select; // RULE6
      nxt_clk.self_clock_mode  = nxt_slf;
      nxt_clk.pll_enable       = nxt_slf || nxt_state == ST_RUN; // RULE3
      nxt_clk.regulator_enable = nxt_slf || nxt_state == ST_RUN;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state_ff    <= ST_RUN;
         cfg_ff      <= CFG_RST;
         flag_ff     <= FLAG_RST;
         ien_ff      <= IEN_RST;
         slf_ff      <= 1'b0;
         wake_rst_ff <= 1'b0;
         mfr_ff      <= 1'b0;
         rstart_ff   <= 1'b0;
         irq_ff      <= 1'b0;
         rdata_ff    <= '0;
         clk_ff      <= CLK_RST;
      end else begin
         state_ff    <= nxt_state;
         cfg_ff      <= nxt_cfg;
         flag_ff     <= nxt_flag;
         ien_ff      <= nxt_ien;
         slf_ff      <= nxt_slf;
         wake_rst_ff <= nxt_wake_rst;
         mfr_ff      <= nxt_mfr;
         rstart_ff   <= nxt_rstart;
         irq_ff      <= nxt_irq;
         rdata_ff    <= nxt_rdata;
         clk_ff      <= nxt_clk;
      end
   end

   assign rdata_o              = rdata_ff;
   assign clk_ctl_o            = clk_ff;
   assign monitor_fail_reset_o = mfr_ff;
   assign reset_start_o        = rstart_ff;
   assign irq_o                = irq_ff;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_loss_resets_now: assert property ( // RULE1
      (state_ff == ST_PSTOP && loss_evt_ff && cfg_ff.clock_monitor_enable
       && !cfg_ff.self_clock_mode_enable && !ext_fall) |=> monitor_fail_reset_o)
      else $error("no monitor reset on loss");
   a_no_monitor_idle: assert property ( // RULE1
      (state_ff == ST_PSTOP && !cfg_ff.clock_monitor_enable && !ext_fall && !wake_irq_i)
      |=> state_ff == ST_PSTOP && !monitor_fail_reset_o)
      else $error("loss acted on with monitor off");
   a_self_stays_stopped: assert property ( // RULE2
      (state_ff == ST_PSTOP && mon_loss && cfg_ff.self_clock_mode_enable
       && !ien_ff[FLG_SLF] && !ext_fall)
      |=> state_ff == ST_PSTOP && clk_ctl_o.self_clock_mode && clk_ctl_o.pll_enable
          && clk_ctl_o.regulator_enable && flag_ff[FLG_SLF])
      else $error("self-clock entry in pseudo-stop wrong");
   a_good_ends_self: assert property ( // RULE3
      (chk_good && slf_ff && state_ff == ST_PSTOP && !mon_loss && !ext_fall && !wake_irq_i)
      |=> !clk_ctl_o.self_clock_mode && !clk_ctl_o.pll_enable && !clk_ctl_o.regulator_enable)
      else $error("self-clock kept after good clock");
   a_wake_on_osc: assert property ( // RULE4
      (state_ff == ST_PSTOP && wake_irq_i && !slf_ff && !chk_tmo && !ext_fall && !mon_loss)
      |=> clk_ctl_o.clocks_released && !clk_ctl_o.sys_clk_pll)
      else $error("wake not on oscillator");
   a_endless_checks: assert property ( // RULE5
      state_ff == ST_PSTOP |-> !chk_tmo)
      else $error("pseudo-stop check timed out");
   a_wake_on_pll: assert property ( // RULE6
      (state_ff == ST_PSTOP && wake_irq_i && slf_ff && !chk_good && !ext_fall && !mon_loss)
      |=> clk_ctl_o.clocks_released && clk_ctl_o.sys_clk_pll)
      else $error("self-clock wake not on PLL");
   a_flag_wakes: assert property ( // RULE7
      (state_ff == ST_PSTOP && mon_loss && cfg_ff.self_clock_mode_enable
       && ien_ff[FLG_SLF] && !ext_fall) |=> state_ff == ST_RUN && clk_ctl_o.sys_clk_pll)
      else $error("flag did not wake on PLL");
   a_fstop_reset_check: assert property ( // RULE9
      (state_ff == ST_FSTOP && ext_fall)
      |=> state_ff == ST_FCHECK && cfg_ff == CFG_RST && !clk_ctl_o.clocks_released)
      else $error("full-stop reset did not start check");
   a_check_starts_rst: assert property ( // RULE10
      (state_ff == ST_FCHECK && chk_good && wake_rst_ff) |=> reset_start_o)
      else $error("reset generator not started");
   a_good_releases: assert property ( // RULE12
      (state_ff == ST_FCHECK && chk_good)
      |=> clk_ctl_o.clocks_released ##1 clk_ctl_o.clocks_released || state_ff != ST_RUN)
      else $error("clocks not released");
   a_tmo_monitor_rst: assert property ( // RULE13
      (state_ff == ST_FCHECK && !chk_good && chk_tmo && !wake_rst_ff
       && !cfg_ff.self_clock_mode_enable) |=> monitor_fail_reset_o)
      else $error("no monitor reset on timeout");
   a_exit_clears_pll: assert property ( // RULE14
      (state_ff != ST_RUN && !wr_i ##1 state_ff == ST_RUN) |-> !cfg_ff.pll_select)
      else $error("pll select not cleared on exit");
   a_fstop_blind: assert property ( // RULE15
      (state_ff == ST_FSTOP && !ext_fall && !wake_irq_i)
      |=> state_ff == ST_FSTOP && !monitor_fail_reset_o)
      else $error("full stop left without wake");
   a_stop_select: assert property ( // RULE16
      (state_ff == ST_RUN && stop_req_i && !mon_loss)
      |=> (state_ff == ST_PSTOP) == $past(cfg_ff.pseudo_stop_select))
      else $error("wrong stop mode");

endmodule : scl_stop_ctrl

// ---- verilog/scl_pkg.sv ----
// Constants, types and layouts for the stop-mode clock loss and wake-up controller
package scl_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int FLAG_W = 4;

   // Register word offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_CLEAR  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_STATE  = 3'h4;

   // Control field positions
   localparam int CTRL_MON    = 0;
   localparam int CTRL_SELF   = 1;
   localparam int CTRL_PSEL   = 2;
   localparam int CTRL_PLL    = 3;
   localparam int CTRL_W      = 4;

   // Status, clear and enable bit positions
   localparam int FLG_SLF   = 0;
   localparam int FLG_MFAIL = 1;
   localparam int FLG_GOOD  = 2;
   localparam int FLG_TMO   = 3;

   typedef struct packed {
      logic pll_select;
      logic pseudo_stop_select;
      logic self_clock_mode_enable;
      logic clock_monitor_enable;
   } scl_cfg_s;

   typedef struct packed {
      logic clocks_released;
      logic in_stop;
      logic sys_clk_pll;
      logic self_clock_mode;
      logic pll_enable;
      logic regulator_enable;
   } scl_clk_s;

   localparam scl_cfg_s          CFG_RST  = 4'h3;
   localparam logic [FLAG_W-1:0] FLAG_RST = 4'h0;
   localparam logic [FLAG_W-1:0] IEN_RST  = 4'h0;
   localparam scl_clk_s          CLK_RST  = 6'h23;

   typedef enum logic [3:0] {
      ST_RUN    = 4'h1,
      ST_PSTOP  = 4'h2,
      ST_FSTOP  = 4'h4,
      ST_FCHECK = 4'h8
   } scl_state_e;

   // Timing
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int LOSS_TIME_NS    = 3200;
   localparam int LOSS_CYCLES     = (LOSS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MAX_WINDOWS     = 50;
   localparam int GOOD_OSC_CYCLES = 4096;
   localparam int WINDOW_CYCLES   = 16384;
   localparam int SYNC_STAGES     = 3;

endpackage : scl_pkg

// ---- verilog/scl_quality_check.sv ----
// Clock quality checker: counts oscillator edges inside repeated check windows
`timescale 1ns/1ns
module scl_quality_check #(
   parameter int WINDOW_CYCLES = 16384,
   parameter int GOOD_EDGES    = 4096,
   parameter int MAX_WINDOWS   = 50
) (
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic start_i,
   input  wire logic limited_i,
   input  wire logic abort_i,
   input  wire logic osc_edge_i,
   output logic      good_o,
   output logic      timeout_o,
   output logic      busy_o
);
   localparam int WW = $clog2(WINDOW_CYCLES);
   localparam int EW = $clog2(GOOD_EDGES + 1);
   localparam int NW = $clog2(MAX_WINDOWS + 1);

   logic          busy_ff, nxt_busy, lim_ff, nxt_lim, good_ff, nxt_good, tmo_ff, nxt_tmo;
   logic [WW-1:0] win_ff, nxt_win;
   logic [EW-1:0] edge_ff, nxt_edge;
   logic [NW-1:0] nwin_ff, nxt_nwin;

   always_comb begin
      nxt_busy = busy_ff;
      nxt_lim  = lim_ff;
      nxt_win  = win_ff;
      nxt_edge = edge_ff;
      nxt_nwin = nwin_ff;
      nxt_good = 1'b0;
      nxt_tmo  = 1'b0;
      if (abort_i) begin
         nxt_busy = 1'b0;
      end else if (start_i) begin
         nxt_busy = 1'b1;
         nxt_lim  = limited_i;
         nxt_win  = '0;
         nxt_edge = '0;
         nxt_nwin = '0;
      end else if (busy_ff) begin
         if (osc_edge_i && edge_ff == EW'(GOOD_EDGES - 1)) begin // RULE3
            nxt_good = 1'b1;
            nxt_busy = 1'b0;
         end else if (win_ff == WW'(WINDOW_CYCLES - 1)) begin // RULE17
            // A window ran out; start a fresh one from zero edges
            nxt_win  = '0;
            nxt_edge = '0;
            nxt_nwin = nwin_ff + NW'(1);
            if (lim_ff && nwin_ff == NW'(MAX_WINDOWS - 1)) begin // RULE11
               nxt_tmo  = 1'b1;
               nxt_busy = 1'b0;
            end else if (!lim_ff) begin // RULE5
               nxt_nwin = '0;
            end
         end else begin
            nxt_win = win_ff + WW'(1);
            if (osc_edge_i) begin
               nxt_edge = edge_ff + EW'(1);
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         busy_ff <= 1'b0;
         lim_ff  <= 1'b0;
         win_ff  <= '0;
         edge_ff <= '0;
         nwin_ff <= '0;
         good_ff <= 1'b0;
         tmo_ff  <= 1'b0;
      end else begin
         busy_ff <= nxt_busy;
         lim_ff  <= nxt_lim;
         win_ff  <= nxt_win;
         edge_ff <= nxt_edge;
         nwin_ff <= nxt_nwin;
         good_ff <= nxt_good;
         tmo_ff  <= nxt_tmo;
      end
   end

   assign good_o    = good_ff;
   assign timeout_o = tmo_ff;
   assign busy_o    = busy_ff;

   a_tmo_last_window: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE11
      (busy_ff && lim_ff && !abort_i && !start_i && !osc_edge_i
       && win_ff == WW'(WINDOW_CYCLES - 1) && nwin_ff == NW'(MAX_WINDOWS - 1)) |=> timeout_o)
      else $error("check did not time out after last window");

endmodule : scl_quality_check

// ---- tb/scl_osc_model.sv ----
// Oscillator and reset-pin model for the far side of the stop controller
`timescale 1ns/1ns
module scl_osc_model (
   input  wire logic clock_i,
   input  wire logic run_i,
   input  wire logic pin_low_i,
   output logic      osc_o,
   output logic      ext_reset_b_o
);
   logic [1:0] div_ff = 2'h0;
   logic       osc_ff = 1'b0;
   // Period of six system clocks: below the loss limit, under a quarter of the clock rate
   always @(posedge clock_i) begin
      div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      // A dead crystal freezes low
      if (!run_i) osc_ff <= 1'b0;
      else if (div_ff == 2'h2) osc_ff <= ~osc_ff;
   end
   assign osc_o         = osc_ff;
   assign ext_reset_b_o = ~pin_low_i;
endmodule : scl_osc_model

// ---- tb/testbench.sv ----
// Self-checking bench for the stop-mode clock loss and wake-up controller
`timescale 1ns/1ns
module testbench;
   import scl_pkg::*;
   logic clock_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic stop_req_i = 1'b0, wake_irq_i = 1'b0, osc_run = 1'b1, pin_low = 1'b0;
   logic [ADDR_W-1:0] addr_i = 3'h0;
   logic [DATA_W-1:0] wdata_i = 8'h00, rdata_o, d;
   logic osc_clock, ext_reset_b, mf_o, rs_o, irq_o, hit, mf_seen, rs_seen;
   scl_clk_s clk_ctl_o;
   int failures = 0, compares = 0;

   scl_stop_ctrl #(.WINDOW_CYCLES(64), .GOOD_EDGES(8), .MAX_WINDOWS(3), .LOSS_CYCLES(8)) DUT (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .stop_req_i(stop_req_i), .wake_irq_i(wake_irq_i),
      .ext_reset_b_i(ext_reset_b), .osc_clock_i(osc_clock), .clk_ctl_o(clk_ctl_o),
      .monitor_fail_reset_o(mf_o), .reset_start_o(rs_o), .irq_o(irq_o));
   scl_osc_model PARTNER (.clock_i(clock_i), .run_i(osc_run), .pin_low_i(pin_low),
      .osc_o(osc_clock), .ext_reset_b_o(ext_reset_b));

   initial begin
      forever #25 clock_i = ~clock_i;
   end

   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc

   task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rdchk(string name, logic [ADDR_W-1:0] a, logic [7:0] m, logic [7:0] e);
      @(posedge clock_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 check(name, rdata_o & m, e);
   endtask : rdchk

   task automatic pulse(int sel);
      @(posedge clock_i);
      if (sel == 0) stop_req_i <= 1'b1; else wake_irq_i <= 1'b1;
      @(posedge clock_i);
      stop_req_i <= 1'b0; wake_irq_i <= 1'b0;
      cyc(1);
   endtask : pulse

   task automatic pin_reset();
      // Two low cycles pass the pin filter; the start pulse lands after return
      pin_low <= 1'b1;
      cyc(2);
      pin_low <= 1'b0;
   endtask : pin_reset

   // Ends on the chosen event (0 fail reset, 1 reset start, 2 clocks released)
   task automatic wait_ev(int sel, int max, output logic h);
      h = 1'b0; mf_seen = 1'b0; rs_seen = 1'b0;
      for (int i = 0; i < max && !h; i++) begin
         cyc(1);
         mf_seen |= mf_o; rs_seen |= rs_o;
         h = (sel == 0) ? mf_o : (sel == 1) ? rs_o : clk_ctl_o.clocks_released;
      end
   endtask : wait_ev

   task automatic reset_dut();
      rst_b_i <= 1'b0; osc_run <= 1'b1;
      cyc(5);
      rst_b_i <= 1'b1;
      cyc(4);
   endtask : reset_dut

   initial begin
      repeat (20000) @(posedge clock_i);
      failures++;
      finish_test();
   end

   initial begin
      void'($urandom(32'hBBDD));
      reset_dut();
      check("clk reset", 8'(clk_ctl_o), 8'h23);
      rdchk("ctrl", OFS_CTRL, 8'hFF, 8'h03);
      rdchk("state", OFS_STATE, 8'hFF, 8'h01);
      rdchk("unmapped", 3'h5, 8'hFF, 8'h00);
      repeat (4) begin
         d = 8'($urandom);
         wr(OFS_ENABLE, d);
         wr(OFS_STATUS, d);
         rdchk("enable", OFS_ENABLE, 8'hFF, d & 8'h0F);
         rdchk("status ro", OFS_STATUS, 8'hFF, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         reset_dut();
         wr(OFS_CTRL, m ? 8'h0C : 8'h05);
         pulse(0);
         check("pstop", 8'(clk_ctl_o), m ? 8'h18 : 8'h10);
         osc_run <= 1'b0;
         wait_ev(0, 40, hit);
         check("loss reset", 8'(hit), 8'(m == 0));
         if (m) pulse(1);
         cyc(2);
         check("exit", 8'(clk_ctl_o), 8'h23);
         rdchk("ctrl exit", OFS_CTRL, 8'hFF, m ? 8'h04 : 8'h03);
      end
      for (int k = 0; k < 4; k++) begin
         reset_dut();
         wr(OFS_CTRL, 8'h07);
         pulse(0);
         osc_run <= 1'b0;
         cyc(30);
         check("clk loss", 8'(clk_ctl_o), 8'h1F);
         check("irq off", 8'(irq_o), 8'h00);
         rdchk("flag", OFS_STATUS, 8'h01, 8'h01);
         cyc(250 + $urandom % 40);
         check("clk held", 8'(clk_ctl_o), 8'h1F);
         rdchk("checking", OFS_STATE, 8'h30, 8'h30);
         rdchk("no timeout", OFS_STATUS, 8'h08, 8'h00);
         if (k[1]) begin
            osc_run <= 1'b1;
            cyc(200);
            check("clk good", 8'(clk_ctl_o), 8'h10);
         end
         if (k[0]) pin_reset();
         else pulse(1);
         wait_ev(1, 30, hit);
         check("reset start", 8'(hit), 8'(k[0]));
         check("clk exit", 8'(clk_ctl_o), k[1] ? 8'h23 : 8'h2F);
         osc_run <= 1'b1;
         cyc(200);
         check("clk back", 8'(clk_ctl_o), 8'h23);
      end
      reset_dut();
      wr(OFS_ENABLE, 8'h01);
      wr(OFS_CTRL, 8'h07);
      pulse(0);
      osc_run <= 1'b0;
      cyc(30);
      check("self wake", 8'(clk_ctl_o), 8'h2F);
      check("irq on", 8'(irq_o), 8'h01);
      osc_run <= 1'b1;
      wr(OFS_ENABLE, 8'h00);
      cyc(2);
      check("irq masked", 8'(irq_o), 8'h00);
      wr(OFS_ENABLE, 8'h01);
      wr(OFS_CLEAR, 8'h01);
      cyc(2);
      check("irq cleared", 8'(irq_o), 8'h00);
      for (int j = 0; j < 4; j++) begin
         reset_dut();
         wr(OFS_CTRL, (j == 2) ? 8'h01 : (j == 1) ? 8'h0B : 8'h03);
         pulse(0);
         rdchk("fstop", OFS_STATE, 8'h0F, 8'h04);
         if (j >= 2) osc_run <= 1'b0;
         wait_ev(0, 40, hit);
         check("no monitor", 8'(hit), 8'h00);
         check("still stop", 8'(clk_ctl_o), (j == 1) ? 8'h18 : 8'h10);
         if (j == 1) pin_reset();
         else pulse(1);
         if (j < 2) begin
            wait_ev(2, 120, hit);
            check("released", 8'(hit), 8'h01);
            check("no fail", 8'(mf_seen), 8'h00);
            check("clk run", 8'(clk_ctl_o), 8'h23);
            cyc(2);
            check("gen start", 8'(rs_seen | rs_o), 8'(j));
            if (j == 1) rdchk("ctrl dflt", OFS_CTRL, 8'hFF, 8'h03);
         end else if (j == 2) begin
            wait_ev(0, 150, hit);
            check("early fail", 8'(hit), 8'h00);
            wait_ev(0, 120, hit);
            check("fail reset", 8'(hit), 8'h01);
         end else begin
            wait_ev(2, 300, hit);
            check("self entry", 8'(clk_ctl_o), 8'h2F);
         end
      end
      finish_test();
   end
endmodule : testbench
